// [pmusp_port.sv]
// Serial register port of the power management unit
module pmusp_port
  import pmusp_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Serial pins from host
  input  wire pmusp_pins_t  pins,
  output logic              sdo,
  // Status flags from the analog side
  input  wire logic [7:0]   statusFlags,
  // Register controls to the regulators
  output pmusp_ctrl_t       ctrl
);

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  pmusp_pins_t pinsMeta;     // First stage, read by second only
  pmusp_pins_t pinsSync;     // Second stage
  logic [7:0]  statusMeta;   // First stage of status
  logic [7:0]  statusSync;   // Second stage of status
  logic        sclkPrev;     // Last synced clock level

  // Two flops on every outside input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinsMeta   <= '{csN: 1'b1, sclk: 1'b0, sdi: 1'b0};
      pinsSync   <= '{csN: 1'b1, sclk: 1'b0, sdi: 1'b0};
      statusMeta <= '0;
      statusSync <= '0;
    end else begin
      pinsMeta   <= pins;      // RQ1
      pinsSync   <= pinsMeta;
      statusMeta <= statusFlags;
      statusSync <= statusMeta;
    end
  end

  // Serial clock edge finder
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclkPrev <= 1'b0;
    end else begin
      sclkPrev <= pinsSync.sclk;
    end
  end

  logic active;    // Frame open
  logic sclkRise;  // Host clock rose
  logic sclkFall;  // Host clock fell
  assign active   = !pinsSync.csN;
  assign sclkRise = active && pinsSync.sclk && !sclkPrev;
  assign sclkFall = active && !pinsSync.sclk && sclkPrev;

  ////////////////////////////////////////////////////////////////////////////////
  // Bit counter and input shifter
  logic [4:0]         bitCount;  // Bits taken in this frame
  logic [FRAME_W-2:0] shiftIn;   // Bits taken so far
  logic [1:0]         cmd;       // Captured command
  logic               cmdValid;  // Command bits complete

  // Count rising edges, cleared when select goes away
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitCount <= '0;
    end else if (!active) begin
      bitCount <= '0;            // RQ7
    end else if (sclkRise && bitCount != CNT_MAX) begin
      bitCount <= bitCount + 5'h01;
    end
  end

  // Shift in host data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shiftIn <= '0;
    end else if (sclkRise && bitCount < CNT_DATA_END) begin
      shiftIn <= {shiftIn[FRAME_W-3:0], pinsSync.sdi};
    end
  end

  // Capture the two command bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd      <= '0;
      cmdValid <= 1'b0;
    end else if (!active) begin
      cmdValid <= 1'b0;
    end else if (sclkRise && bitCount == CNT_CMD_END) begin
      cmd      <= {shiftIn[0], pinsSync.sdi};  // RQ2 RQ3
      cmdValid <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decode of address and write data
  logic              readReq;   // Read address complete
  logic              wrPulse;   // Full write frame taken
  logic [ADDR_W-1:0] addr;      // Register address
  logic [DATA_W-1:0] wrData;    // Data to store

  // Address capture, read request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr    <= '0;
      readReq <= 1'b0;
    end else begin
      readReq <= 1'b0;
      if (sclkRise && bitCount == CNT_ADDR_END) begin
        addr    <= {shiftIn[3:0], pinsSync.sdi};
        readReq <= (cmd == CMD_READ);       // RQ3
      end
    end
  end

  // Write only after the eighth data bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPulse <= 1'b0;
      wrData  <= '0;
    end else begin
      wrPulse <= 1'b0;
      if (sclkRise && bitCount == CNT_DATA_END && cmd == CMD_WRITE) begin
        wrPulse <= 1'b1;                    // RQ7
        wrData  <= {shiftIn[6:0], pinsSync.sdi};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage and control outputs
  logic [DATA_W-1:0] memData;   // Plain register read data
  logic              readLoad;  // Memory data now valid

  pmusp_reg_mem u_mem (
    .clk    (clk),
    .rst_n  (rst_n),
    .wrEn   (wrPulse),
    .wrAddr (addr),
    .wrData (wrData),
    .rdAddr (addr),
    .rdData (memData)
  );

  // Control registers written from the port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '{devEnable: RST_DEVEN, buck3Volt: RST_BUCK3, buck1Volt: RST_BUCK1,
                buck2Volt: RST_BUCK2, buckCtl: RST_BUCKCTL, compCtl: RST_COMP};
    end else if (wrPulse) begin
      case (addr)
        OFS_BUCK3:   ctrl.buck3Volt <= wrData[6:0];  // RQ5
        OFS_BUCK1:   ctrl.buck1Volt <= wrData[5:0];  // RQ5
        OFS_BUCK2:   ctrl.buck2Volt <= wrData[5:0];  // RQ5
        OFS_BUCKCTL: ctrl.buckCtl   <= wrData[4:0];  // RQ6
        OFS_COMP:    ctrl.compCtl   <= wrData;       // RQ6
        OFS_DEVEN:   ctrl.devEnable <= wrData[0];    // RQ5
        default:     ctrl           <= ctrl;         // Plain storage only
      endcase
    end
  end

  // Memory read data valid one cycle later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readLoad <= 1'b0;
    end else begin
      readLoad <= readReq;
    end
  end

  // Read value selection
  logic [DATA_W-1:0] readValue;
  always_comb begin
    case (addr)
      OFS_BUCK3:   readValue = {1'b0, ctrl.buck3Volt};
      OFS_BUCK1:   readValue = {2'b00, ctrl.buck1Volt};
      OFS_BUCK2:   readValue = {2'b00, ctrl.buck2Volt};
      OFS_BUCKCTL: readValue = {3'b000, ctrl.buckCtl};
      OFS_COMP:    readValue = ctrl.compCtl;
      OFS_STATUS:  readValue = statusSync;           // RQ5
      OFS_DEVEN:   readValue = {7'h00, ctrl.devEnable};
      default:     readValue = memData;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output shifter
  logic [DATA_W-1:0] shiftOut;   // Read data still to send
  logic              readPhase;  // Data phase of a read

  // Load when memory data is valid, shift on falling host clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shiftOut  <= '0;
      readPhase <= 1'b0;
      sdo       <= 1'b0;
    end else if (!active) begin
      readPhase <= 1'b0;
      sdo       <= 1'b0;
    end else if (readLoad) begin
      shiftOut  <= readValue;
      readPhase <= 1'b1;
    end else if (sclkFall && readPhase) begin
      sdo      <= shiftOut[DATA_W-1];               // RQ4
      shiftOut <= {shiftOut[DATA_W-2:0], 1'b0};
    end else if (!readPhase) begin
      sdo <= 1'b0;                                  // RQ2
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_read_addr;
    readReq ##1 readLoad;
  endsequence

  sequence s_read_ready;
    readPhase && shiftOut == $past(readValue);
  endsequence

  a_read_loads: assert property (@(posedge clk) disable iff (!rst_n)
    s_read_addr and (active [*2]) |=> s_read_ready)                   // RQ4
    else $error("read data not loaded after address");

  a_read_cmd: assert property (@(posedge clk) disable iff (!rst_n)
    readReq |-> cmd == CMD_READ && bitCount == 5'h07)                 // RQ3
    else $error("read request without read command");

  a_write_sdo_low: assert property (@(posedge clk) disable iff (!rst_n)
    cmdValid && cmd == CMD_WRITE |-> sdo == 1'b0)                     // RQ2
    else $error("data output not low during write");

  a_cs_clears: assert property (@(posedge clk) disable iff (!rst_n)
    !active |=> bitCount == 5'h00 && !readPhase)                      // RQ7
    else $error("frame state kept after deselect");

  a_write_full: assert property (@(posedge clk) disable iff (!rst_n)
    wrPulse |-> bitCount == 5'h0f && cmd == CMD_WRITE)                // RQ7
    else $error("write before eighth data bit");

  a_buck1_set: assert property (@(posedge clk) disable iff (!rst_n)
    wrPulse && addr == OFS_BUCK1 |=> ctrl.buck1Volt == $past(wrData[5:0])) // RQ5
    else $error("buck 1 code not updated");

  a_comp_set: assert property (@(posedge clk) disable iff (!rst_n)
    wrPulse && addr == OFS_COMP |=> ctrl.compCtl == $past(wrData))    // RQ6
    else $error("comparator control not updated");

  a_sdo_msb: assert property (@(posedge clk) disable iff (!rst_n)
    active && readPhase && sclkFall && !readLoad |=> sdo == $past(shiftOut[7])) // RQ4
    else $error("read bit out of order");

  a_sync_depth: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(pinsSync.csN) |-> $past(pins.csN, 3) == 1'b0 || $past(pins.csN, 2) == 1'b0) // RQ1
    else $error("select seen without two stages");

endmodule : pmusp_port

// [pmusp_pkg.sv]
// Package and register memory for the power unit serial register port
// Functional notes
// RQ1 - Four wires: select, clock, data in, out
// RQ2 - Write: 10, address, data; output low
// RQ3 - Read: 11, then five address bits
// RQ4 - Read data out MSB first, input ignored
// RQ5 - Enable device, set bucks, read status
// RQ6 - Program comparator reference, control bucks
// RQ7 - Select frames transfer; write after data
package pmusp_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame layout
  localparam int unsigned ADDR_W      = 5;     // Register address width
  localparam int unsigned DATA_W      = 8;     // Register data width
  localparam int unsigned FRAME_W     = 15;    // Command, address, data bits
  localparam logic [4:0]  CNT_CMD_END = 5'h01; // Count at second command bit
  localparam logic [4:0]  CNT_ADDR_END = 5'h06; // Count at address bit 0
  localparam logic [4:0]  CNT_DATA_END = 5'h0e; // Count at data bit 0
  localparam logic [4:0]  CNT_MAX     = 5'h10; // Counter saturation point
  localparam logic [1:0]  CMD_WRITE   = 2'h2;  // Bits 1 then 0
  localparam logic [1:0]  CMD_READ    = 2'h3;  // Bits 1 then 1

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [4:0] OFS_BUCK3   = 5'h00; // Buck 3 voltage code
  localparam logic [4:0] OFS_BUCK1   = 5'h07; // Buck 1 voltage code
  localparam logic [4:0] OFS_BUCK2   = 5'h08; // Buck 2 voltage code
  localparam logic [4:0] OFS_BUCKCTL = 5'h0a; // Buck control
  localparam logic [4:0] OFS_COMP    = 5'h0b; // Comparator control
  localparam logic [4:0] OFS_STATUS  = 5'h0c; // Status flags, read only
  localparam logic [4:0] OFS_DEVEN   = 5'h0d; // Device enable

  ////////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [6:0] RST_BUCK3   = 7'h64;
  localparam logic [5:0] RST_BUCK1   = 6'h26;
  localparam logic [5:0] RST_BUCK2   = 6'h0e;
  localparam logic [4:0] RST_BUCKCTL = 5'h02;
  localparam logic [7:0] RST_COMP    = 8'h33;
  localparam logic       RST_DEVEN   = 1'h1;

  ////////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic csN;   // Chip select, active low
    logic sclk;  // Serial clock from host
    logic sdi;   // Serial data in
  } pmusp_pins_t;

  typedef struct packed {
    logic       devEnable;  // Whole device enable
    logic [6:0] buck3Volt;  // Buck 3 voltage code
    logic [5:0] buck1Volt;  // Buck 1 voltage code
    logic [5:0] buck2Volt;  // Buck 2 voltage code
    logic [4:0] buckCtl;    // Forced PWM and enable bits
    logic [7:0] compCtl;    // Hysteresis, threshold, enable
  } pmusp_ctrl_t;

endpackage : pmusp_pkg

////////////////////////////////////////////////////////////////////////////////
// Register memory with registered read data
module pmusp_reg_mem
  import pmusp_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Write side
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [DATA_W-1:0] wrData,
  // Read side
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [DATA_W-1:0] rdData
);

  logic [DATA_W-1:0] mem [2**ADDR_W]; // Storage array

  // Write port
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // Read port, data from a register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= '0;
    end else begin
      rdData <= mem[rdAddr];
    end
  end

endmodule : pmusp_reg_mem

// [pmusp_host_model.sv]
// Host serial master model for the register port
module pmusp_host_model
  import pmusp_pkg::*;
(
  // Clock
  input  wire logic   clk,
  // Serial pins
  output pmusp_pins_t pins,
  input  wire logic   sdo
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle: deselected, clock low
  initial begin
    pins = {1'b1, 1'b0, 1'b1};
  end

  // Wait n clocks, land just after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // One framed transfer, MSB first, mode 0
  task automatic xfer(input logic [14:0] frame, input int nBits,
                      output logic [7:0] rd, output logic lowSeen);
    rd = 8'h00;
    lowSeen = 1'b1;
    pins.csN = 1'b0;
    tick(4);
    for (int i = 0; i < nBits; i++) begin
      pins.sdi = frame[14-i];
      tick(4);
      pins.sclk = 1'b1;
      tick(3);
      // Capture data phase bits
      if (i >= 7) begin
        rd = {rd[6:0], sdo};
      end
      if (sdo !== 1'b0) begin
        lowSeen = 1'b0;
      end
      tick(1);
      pins.sclk = 1'b0;
    end
    // Released line shows no stale value
    pins.sdi = ~pins.sdi;
    tick(4);
    pins.csN = 1'b1;
    tick(4);
  endtask : xfer
endmodule : pmusp_host_model

// [pmu_serial_register_port_tb.sv]
// Testbench for the power unit serial register port
module pmu_serial_register_port_tb
  import pmusp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////////////
  // Signals
  logic        clk;
  logic        rst_n;
  pmusp_pins_t pins;
  logic        sdo;
  logic [7:0]  statusFlags;
  pmusp_ctrl_t ctrl;
  pmusp_ctrl_t expCtrl;     // Expected control outputs
  int          n_mismatch;
  int          comparisons;
  int          seed = 33312;
  int          cycles;
  logic [7:0]  d;
  logic [7:0]  q;
  logic        low;
  logic [4:0]  a;
  logic [4:0]  offs [7] = '{OFS_BUCK3, OFS_BUCK1, OFS_BUCK2, OFS_BUCKCTL,
                            OFS_COMP, OFS_DEVEN, 5'h15};

  // Design and host
  pmusp_port uut (.clk(clk), .rst_n(rst_n), .pins(pins), .sdo(sdo),
                  .statusFlags(statusFlags), .ctrl(ctrl));
  pmusp_host_model host (.clk(clk), .pins(pins), .sdo(sdo));

  // Clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Bits that a register keeps
  function automatic logic [7:0] keepMask(input logic [4:0] ad);
    case (ad)
      OFS_BUCK3:   return 8'h7f;
      OFS_BUCK1:   return 8'h3f;
      OFS_BUCK2:   return 8'h3f;
      OFS_BUCKCTL: return 8'h1f;
      OFS_DEVEN:   return 8'h01;
      default:     return 8'hff;
    endcase
  endfunction : keepMask

  // Control outputs after a write
  function automatic pmusp_ctrl_t applyWr(input pmusp_ctrl_t c, input logic [4:0] ad,
                                          input logic [7:0] v);
    case (ad)
      OFS_BUCK3:   c.buck3Volt = v[6:0];
      OFS_BUCK1:   c.buck1Volt = v[5:0];
      OFS_BUCK2:   c.buck2Volt = v[5:0];
      OFS_BUCKCTL: c.buckCtl = v[4:0];
      OFS_COMP:    c.compCtl = v;
      OFS_DEVEN:   c.devEnable = v[0];
      default:     ;
    endcase
    return c;
  endfunction : applyWr

  // Compare and count
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Register write, output low, controls updated
  task automatic wr(input logic [4:0] ad, input logic [7:0] v);
    host.xfer({CMD_WRITE, ad, v}, 15, q, low);
    expCtrl = applyWr(expCtrl, ad, v);
    chk(low, 1'b1);
    chk(ctrl, expCtrl);
  endtask : wr

  // Register read with junk after the address
  task automatic rd(input logic [4:0] ad, output logic [7:0] v);
    host.xfer({CMD_READ, ad, 8'($random(seed))}, 15, v, low);
    chk(sdo, 1'b0);
  endtask : rd

  // Counts and verdict
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    statusFlags = 8'h00;
    expCtrl = {RST_DEVEN, RST_BUCK3, RST_BUCK1, RST_BUCK2, RST_BUCKCTL, RST_COMP};
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    host.tick(3);
    chk(ctrl, expCtrl);
    chk(sdo, 1'b0);
    // Extremes then random, every control register and one plain address
    foreach (offs[i]) begin
      for (int k = 0; k < 3; k++) begin
        d = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($random(seed));
        wr(offs[i], d);
        rd(offs[i], q);
        chk(q & keepMask(offs[i]), d & keepMask(offs[i]));
      end
    end
    // Status flags read back, writes there ignored
    statusFlags = 8'($random(seed));
    wr(OFS_STATUS, ~statusFlags);
    rd(OFS_STATUS, q);
    chk(q, statusFlags);
    // Short write frame stores nothing
    host.xfer({CMD_WRITE, OFS_COMP, ~expCtrl.compCtl}, 14, q, low);
    chk(ctrl, expCtrl);
    // Commands 00 and 01 do nothing
    for (int c = 0; c < 2; c++) begin
      host.xfer({2'(c), OFS_COMP, ~expCtrl.compCtl}, 15, q, low);
      chk(ctrl, expCtrl);
      chk(low, 1'b1);
    end
    // Random back-to-back traffic
    repeat (20) begin
      a = offs[$unsigned($random(seed)) % 7];
      d = 8'($random(seed));
      wr(a, d);
      rd(a, q);
      chk(q & keepMask(a), d & keepMask(a));
    end
    // Reset in mid-run restores every control, port still works
    rst_n = 1'b0;
    expCtrl = {RST_DEVEN, RST_BUCK3, RST_BUCK1, RST_BUCK2, RST_BUCKCTL, RST_COMP};
    host.tick(2);
    rst_n = 1'b1;
    host.tick(3);
    chk(ctrl, expCtrl);
    chk(sdo, 1'b0);
    wr(OFS_COMP, 8'h5a);
    rd(OFS_COMP, q);
    chk(q, 8'h5a);
    give_verdict();
  end
endmodule : pmu_serial_register_port_tb
